// *** include/battery_charge_cfg.svh ***
// Behaviour
// - High impedance: charger and boost off, current blocked both ways.
// - Linear precharge below short threshold, then slew-limited constant-current PWM.
// - Cut charge current while junction is at or above 120 C.
// - Below pathmode exit voltage, path switch runs linear, system rail above 3.4 V.
// - Cut input current as input voltage nears its floor, typically 4.5 V.
// - In voltage regulation, charge ends at termination current.
// - Termination acts only while termination_enable, register 1 bit 3, is 1.
// - Float voltage 3.50 V plus 20 mV per code; codes 47 to 63 give 4.44 V.
// - Register 1 holds input limit code 7:6 and weak-battery code 5:4.
// - Charge current 550 mA plus 100 mA per code; codes 10 to 15 give 1550 mA.
// - While low_current_select is set, the default, current is 340 mA.
// - Low-side switch off at 140 mA reverse current.
// - Termination and top-off codes select 50 mA times code plus one.
// - Termination stops PWM, status low; then status high, bits 10, if connected.
// - topoff_enable set at charge end starts post-charge, sets topoff_active.
// - When enabled, restart on drop below recharge level or any write.
// - Auto-charge variants charge at power-on reset if battery is weak.
// - Post-charge termination stops PWM, clears topoff_active.
// - Post-charge keeps status high; exits on reset, power-good cycle, mode toggle.
`ifndef BATTERY_CHARGE_CFG_SVH
`define BATTERY_CHARGE_CFG_SVH

// Register indexes; the byte address is four times the index.
`define REG0_IDX 3'h0
`define REG1_IDX 3'h1
`define REG2_IDX 3'h2
`define REG4_IDX 3'h4
`define REG7_IDX 3'h7

// Field positions.
`define REG0_STATUS_LSB 4
`define REG0_TMR_RST_BIT 7
`define REG1_ILIM_LSB 6
`define REG1_WEAK_LSB 4
`define REG1_TE_BIT 3
`define REG1_CDIS_N_BIT 2
`define REG1_HIZ_BIT 1
`define REG2_FLOAT_LSB 2
`define REG4_LOWI_BIT 7
`define REG4_CHG_LSB 3
`define REG4_TERM_LSB 0
`define REG7_ACTIVE_BIT 4
`define REG7_EN_BIT 3
`define REG7_TOPOFF_LSB 0

// Reset values.
`define ILIM_RST 2'h0
`define WEAK_RST 2'h0
`define TE_RST 1'b1
`define FLOAT_RST 6'h02
`define CHG_RST 4'h0
`define TERM_RST 3'h0
`define TOPOFF_RST 3'h0

// Decode figures.
`define FLOAT_BASE_MV 13'h0DAC
`define FLOAT_STEP_MV 13'h0014
`define FLOAT_MAX_CODE 6'h2E
`define FLOAT_SAT_MV 13'h1158
`define CHG_BASE_MA 11'h226
`define CHG_STEP_MA 11'h064
`define CHG_MAX_CODE 4'h9
`define CHG_SAT_MA 11'h60E
`define CHG_LOW_MA 11'h154
`define TERM_STEP_MA 9'h032

// Timing.
`define CLK_HZ 25000000
`define T32_S 32
`define POR_SETTLE 2'h3
`define TOPOFF_SETTLE 3'h4

// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** include/battery_charge_pkg.sv ***
package battery_charge_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRECHARGE = 3'b001,
    ST_CONST_CURRENT = 3'b010,
    ST_CONST_VOLTAGE = 3'b011,
    ST_TERM_STOP = 3'b100,
    ST_DONE = 3'b101,
    ST_TOPOFF = 3'b110
  } charge_state_t;

  // Analog comparator levels; all asynchronous to aclk.
  typedef struct packed {
    logic batt_below_short;
    logic batt_below_pathmode;
    logic batt_below_weak;
    logic batt_below_float;
    logic batt_below_recharge;
    logic batt_below_3v0;
    logic current_below_term;
    logic junction_hot;
    logic vbus_near_floor;
    logic low_side_reverse;
    logic batt_connected;
    logic disable_pin;
  } sense_t;

  // Switch and loop commands to the analog side.
  typedef struct packed {
    logic hiz_block;
    logic boost_off;
    logic linear_precharge;
    logic pwm_on;
    logic slew_limit;
    logic thermal_cut;
    logic path_linear;
    logic input_cutback;
    logic low_side_en;
    logic status_pin;
    logic power_good_n;
  } drive_t;

  // Decoded regulation targets.
  typedef struct packed {
    logic [12:0] float_mv;
    logic [10:0] charge_ma;
    logic [8:0] term_ma;
    logic [1:0] input_limit_code;
    logic [1:0] weak_code;
  } setpoint_t;

endpackage

// *** rtl/charge_code_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "battery_charge_cfg.svh"

// Programmed codes to regulation targets.
module charge_code_decode (
  input wire logic [5:0] float_voltage_code,
  input wire logic [3:0] charge_current_code,
  input wire logic low_current_select,
  input wire logic [2:0] term_current_code,
  input wire logic [2:0] topoff_term_code,
  input wire logic use_topoff,
  input wire logic [1:0] input_current_limit_code,
  input wire logic [1:0] weak_code,
  output battery_charge_pkg::setpoint_t setpoint
);

  // Both termination codes share one scale.
  function automatic logic [8:0] term_ma(input logic [2:0] code);
    term_ma = 9'(`TERM_STEP_MA * ({6'h00, code} + 9'h001));
  endfunction

  logic [2:0] term_sel;

  // Top-off threshold replaces the normal one while post-charging.
  always_comb
  begin
    term_sel = use_topoff ? topoff_term_code : term_current_code;
    setpoint.term_ma = term_ma(term_sel);
    if (float_voltage_code > `FLOAT_MAX_CODE)
      setpoint.float_mv = `FLOAT_SAT_MV;
    else
      setpoint.float_mv = 13'(`FLOAT_BASE_MV + `FLOAT_STEP_MV * {7'h00, float_voltage_code});
    if (low_current_select)
      setpoint.charge_ma = `CHG_LOW_MA;
    else if (charge_current_code > `CHG_MAX_CODE)
      setpoint.charge_ma = `CHG_SAT_MA;
    else
      setpoint.charge_ma = 11'(`CHG_BASE_MA + `CHG_STEP_MA * {7'h00, charge_current_code});
    setpoint.input_limit_code = input_current_limit_code;
    setpoint.weak_code = weak_code;
  end

endmodule
`default_nettype wire

// *** rtl/battery_charge_control.sv ***
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "battery_charge_cfg.svh"

module battery_charge_control #(
  parameter bit AUTO_CHARGE = 1'b1,
  parameter int unsigned T32_CYCLES = `T32_S * `CLK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire battery_charge_pkg::sense_t sense_async,
  output battery_charge_pkg::drive_t drive,
  output battery_charge_pkg::setpoint_t setpoint
);

  ////////////////////////////////////////
  // Address decoding shared by both bus directions.

  function automatic logic is_mapped(input logic [7:0] addr);
    logic [2:0] idx;
    idx = addr[4:2];
    is_mapped = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0) &&
                (idx == `REG0_IDX || idx == `REG1_IDX || idx == `REG2_IDX ||
                 idx == `REG4_IDX || idx == `REG7_IDX);
  endfunction

  function automatic logic [2:0] index_of(input logic [7:0] addr);
    index_of = addr[4:2];
  endfunction

  ////////////////////////////////////////
  // Declarations.

  battery_charge_pkg::sense_t sense_meta;
  battery_charge_pkg::sense_t sense;
  battery_charge_pkg::charge_state_t state;
  battery_charge_pkg::setpoint_t next_setpoint;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic [1:0] input_current_limit_code;
  logic [1:0] weak_code;
  logic termination_enable;
  logic charge_disable_n;
  logic high_impedance_select;
  logic [5:0] float_voltage_code;
  logic low_current_select;
  logic [3:0] charge_current_code;
  logic [2:0] term_current_code;
  logic topoff_enable;
  logic [2:0] topoff_term_code;
  logic topoff_active;
  logic [2:0] topoff_wait;
  logic [29:0] t32_count;
  logic t32_running;
  logic load_defaults;
  logic [1:0] por_count;
  logic por_check;
  logic cdis_prev;
  logic hiz_prev;
  logic mode_toggle;
  logic pg_prev;
  logic pg_cycle;
  logic enabled;
  logic [1:0] status_bits;
  logic [7:0] read_byte;

  ////////////////////////////////////////
  // Comparator levels cross into aclk through two flip-flops.

  always_ff @(posedge aclk)
  begin
    sense_meta <= sense_async;
    sense <= sense_meta;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order, then answered.

  assign wr_fire = aw_hold && w_hold && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      else if (!aw_hold)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        w_hold <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
        wready <= 1'b0;
      end
      else if (!w_hold)
        wready <= 1'b1;
      if (wr_fire)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programmed codes. Only byte lane 0 carries register bits.

  always_ff @(posedge aclk)
  begin
    if (!aresetn || load_defaults)
    begin
      input_current_limit_code <= `ILIM_RST;
      weak_code <= `WEAK_RST;
      termination_enable <= `TE_RST;
      charge_disable_n <= 1'b0;
      high_impedance_select <= 1'b0;
      float_voltage_code <= `FLOAT_RST;
      low_current_select <= 1'b1;
      charge_current_code <= `CHG_RST;
      term_current_code <= `TERM_RST;
      topoff_enable <= 1'b0;
      topoff_term_code <= `TOPOFF_RST;
    end
    else if (wr_fire && w_lane0 && is_mapped(aw_addr))
    begin
      case (index_of(aw_addr))
        `REG1_IDX:
        begin
          input_current_limit_code <= w_byte[`REG1_ILIM_LSB +: 2];
          weak_code <= w_byte[`REG1_WEAK_LSB +: 2];
          termination_enable <= w_byte[`REG1_TE_BIT];
          charge_disable_n <= w_byte[`REG1_CDIS_N_BIT];
          high_impedance_select <= w_byte[`REG1_HIZ_BIT];
        end
        `REG2_IDX: float_voltage_code <= w_byte[`REG2_FLOAT_LSB +: 6];
        `REG4_IDX:
        begin
          low_current_select <= w_byte[`REG4_LOWI_BIT];
          charge_current_code <= w_byte[`REG4_CHG_LSB +: 4];
          term_current_code <= w_byte[`REG4_TERM_LSB +: 3];
        end
        `REG7_IDX:
        begin
          topoff_enable <= w_byte[`REG7_EN_BIT];
          topoff_term_code <= w_byte[`REG7_TOPOFF_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////
  // Host watchdog: any write restarts it; on expiry the codes fall back to
  // defaults, so a silent host cannot leave an aggressive profile in force.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t32_count <= 30'h00000000;
      t32_running <= 1'b0;
      load_defaults <= 1'b0;
    end
    else
    begin
      load_defaults <= 1'b0;
      if (wr_fire)
      begin
        t32_count <= 30'h00000000;
        t32_running <= 1'b1;
      end
      else if (t32_running)
      begin
        if (t32_count == 30'(T32_CYCLES - 1))
        begin
          t32_running <= 1'b0;
          load_defaults <= 1'b1;
        end
        else
          t32_count <= t32_count + 30'h00000001;
      end
    end
  end

  ////////////////////////////////////////
  // Power-on check waits for the synchronisers to fill.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_count <= 2'h0;
      por_check <= 1'b0;
    end
    else
    begin
      por_check <= (por_count == `POR_SETTLE - 2'h1);
      if (por_count != `POR_SETTLE)
        por_count <= por_count + 2'h1;
    end
  end

  // Edge history for the post-charge exit events.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cdis_prev <= 1'b0;
      hiz_prev <= 1'b0;
      pg_prev <= 1'b1;
    end
    else
    begin
      cdis_prev <= charge_disable_n;
      hiz_prev <= high_impedance_select;
      pg_prev <= drive.power_good_n;
    end
  end

  assign mode_toggle = (cdis_prev != charge_disable_n) || (hiz_prev != high_impedance_select);
  assign pg_cycle = !pg_prev && drive.power_good_n && sense.batt_below_3v0;
  assign enabled = !sense.disable_pin && !charge_disable_n && !high_impedance_select;

  ////////////////////////////////////////
  // Charge sequencer.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= battery_charge_pkg::ST_IDLE;
      topoff_active <= 1'b0;
      topoff_wait <= 3'h0;
    end
    else
    begin
      case (state)
        battery_charge_pkg::ST_IDLE:
          if (enabled && (wr_fire || (AUTO_CHARGE && por_check && sense.batt_below_weak)))
            state <= battery_charge_pkg::ST_PRECHARGE;
        battery_charge_pkg::ST_PRECHARGE:
          if (!enabled)
            state <= battery_charge_pkg::ST_IDLE;
          else if (!sense.batt_below_short)
            state <= battery_charge_pkg::ST_CONST_CURRENT;
        battery_charge_pkg::ST_CONST_CURRENT:
          if (!enabled)
            state <= battery_charge_pkg::ST_IDLE;
          else if (sense.batt_below_short)
            state <= battery_charge_pkg::ST_PRECHARGE;
          else if (!sense.batt_below_float)
            state <= battery_charge_pkg::ST_CONST_VOLTAGE;
        battery_charge_pkg::ST_CONST_VOLTAGE:
          if (!enabled)
            state <= battery_charge_pkg::ST_IDLE;
          else if (termination_enable && sense.current_below_term)
            state <= battery_charge_pkg::ST_TERM_STOP;
        battery_charge_pkg::ST_TERM_STOP:
          if (!sense.batt_connected)
            state <= battery_charge_pkg::ST_IDLE;
          else if (topoff_enable)
          begin
            state <= battery_charge_pkg::ST_TOPOFF;
            topoff_active <= 1'b1;
            topoff_wait <= `TOPOFF_SETTLE;
          end
          else
            state <= battery_charge_pkg::ST_DONE;
        battery_charge_pkg::ST_TOPOFF:
          if (mode_toggle || pg_cycle)
          begin
            state <= battery_charge_pkg::ST_IDLE;
            topoff_active <= 1'b0;
          end
          else if (topoff_wait != 3'h0)
            topoff_wait <= topoff_wait - 3'h1; // Old threshold still in the synchroniser.
          else if (sense.current_below_term)
          begin
            state <= battery_charge_pkg::ST_DONE;
            topoff_active <= 1'b0;
          end
        battery_charge_pkg::ST_DONE:
          if (!enabled)
            state <= battery_charge_pkg::ST_IDLE;
          else if (sense.batt_below_recharge || wr_fire)
            state <= battery_charge_pkg::ST_PRECHARGE;
        default: state <= battery_charge_pkg::ST_IDLE;
      endcase
    end
  end

  // Status bits: 00 ready, 01 charging, 10 charge done.
  always_comb
  begin
    case (state)
      battery_charge_pkg::ST_DONE, battery_charge_pkg::ST_TOPOFF: status_bits = 2'h2;
      battery_charge_pkg::ST_IDLE: status_bits = 2'h0;
      default: status_bits = 2'h1;
    endcase
  end

  ////////////////////////////////////////
  // Analog commands, registered so every output comes from a flop.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      drive <= '{hiz_block: 1'b1, boost_off: 1'b1, power_good_n: 1'b1, default: 1'b0};
    else
    begin
      drive.hiz_block <= high_impedance_select;
      drive.boost_off <= 1'b1;
      drive.linear_precharge <= !high_impedance_select && state == battery_charge_pkg::ST_PRECHARGE;
      drive.pwm_on <= !high_impedance_select && !sense.disable_pin &&
        (state == battery_charge_pkg::ST_CONST_CURRENT || state == battery_charge_pkg::ST_CONST_VOLTAGE ||
         state == battery_charge_pkg::ST_TOPOFF);
      drive.slew_limit <= state == battery_charge_pkg::ST_CONST_CURRENT;
      drive.thermal_cut <= sense.junction_hot;
      drive.path_linear <= !high_impedance_select && sense.batt_below_pathmode;
      drive.input_cutback <= sense.vbus_near_floor;
      drive.low_side_en <= !high_impedance_select && !sense.low_side_reverse &&
        (state == battery_charge_pkg::ST_CONST_CURRENT || state == battery_charge_pkg::ST_CONST_VOLTAGE ||
         state == battery_charge_pkg::ST_TOPOFF);
      drive.status_pin <= state == battery_charge_pkg::ST_DONE || state == battery_charge_pkg::ST_TOPOFF;
      drive.power_good_n <= sense.batt_below_pathmode || sense.batt_below_weak;
    end
  end

  // Targets for the regulation loops.
  charge_code_decode u_decode (
    .float_voltage_code(float_voltage_code),
    .charge_current_code(charge_current_code),
    .low_current_select(low_current_select),
    .term_current_code(term_current_code),
    .topoff_term_code(topoff_term_code),
    .use_topoff(topoff_active),
    .input_current_limit_code(input_current_limit_code),
    .weak_code(weak_code),
    .setpoint(next_setpoint)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      setpoint <= '0;
    else
      setpoint <= next_setpoint;
  end

  ////////////////////////////////////////
  // Read channel.

  always_comb
  begin
    read_byte = 8'h00;
    case (index_of(araddr))
      `REG0_IDX: read_byte[`REG0_STATUS_LSB +: 2] = status_bits;
      `REG1_IDX: read_byte = {input_current_limit_code, weak_code, termination_enable,
                              charge_disable_n, high_impedance_select, 1'b0};
      `REG2_IDX: read_byte = {float_voltage_code, 2'h0};
      `REG4_IDX: read_byte = {low_current_select, charge_current_code, term_current_code};
      `REG7_IDX: read_byte = {3'h0, topoff_active, topoff_enable, topoff_term_code};
      default: read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= is_mapped(araddr) ? {24'h000000, read_byte} : 32'h00000000;
      rresp <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

endmodule
`default_nettype wire

// *** verif/battery_charge_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// Checks bus answers, targets and analog commands.
module battery_charge_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire battery_charge_pkg::sense_t sense_async,
  input wire battery_charge_pkg::drive_t drive,
  input wire battery_charge_pkg::setpoint_t setpoint
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Answers stand until the master takes them; a read is answered the cycle after it is taken.
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("Write answer dropped early.");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("Read answer dropped early.");
  property p_rans;
    arvalid && arready |=> rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("Read answer late.");
  // Drive lags the mode by a cycle.
  property p_hiz;
    drive.hiz_block [*3] |-> drive.boost_off && !drive.pwm_on && !drive.linear_precharge;
  endproperty
  a_hiz: assert property (p_hiz) else $error("Charger active while blocked.");
  property p_mode;
    !(drive.pwm_on && drive.linear_precharge);
  endproperty
  a_mode: assert property (p_mode) else $error("Linear and switching charge together.");
  // Targets are judged once the decoder has caught up.
  property p_float;
    $past(aresetn) |-> setpoint.float_mv inside {[13'h0DAC:13'h1158]} && setpoint.float_mv % 13'h14 == 13'h0;
  endproperty
  a_float: assert property (p_float) else $error("Float target off the grid.");
  property p_chg;
    $past(aresetn) |-> setpoint.charge_ma == 11'h154 ||
      (setpoint.charge_ma inside {[11'h226:11'h60E]} && setpoint.charge_ma % 11'h64 == 11'h32);
  endproperty
  a_chg: assert property (p_chg) else $error("Charge target off the grid.");
  // Sync and drive take three edges; five leave margin.
  property p_hot;
    sense_async.junction_hot [*5] |-> drive.thermal_cut;
  endproperty
  a_hot: assert property (p_hot) else $error("No thermal cutback.");
endmodule
bind battery_charge_control battery_charge_props u_props (.*);
`default_nettype wire

// *** verif/battery_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Battery and supply as comparator outputs.
module battery_model #(
  parameter logic [12:0] SHORT_MV = 13'h07D0,
  parameter logic [12:0] RCH_MV = 13'h0078
) (
  input wire battery_charge_pkg::setpoint_t setpoint,
  input wire logic [12:0] batt_mv,
  input wire logic [10:0] batt_ma,
  input wire logic [3:0] flags,
  output var battery_charge_pkg::sense_t sense_async
);
  // Plain comparators; a level equal to a threshold, as the bench sets for pathmode and float, reads as not below.
  always_comb
  begin
    sense_async.batt_below_short = batt_mv < SHORT_MV;
    sense_async.batt_below_pathmode = batt_mv < 13'h0CE4;
    sense_async.batt_below_weak = batt_mv < 13'h0D48;
    sense_async.batt_below_float = batt_mv < setpoint.float_mv;
    sense_async.batt_below_recharge = batt_mv < setpoint.float_mv - RCH_MV;
    sense_async.batt_below_3v0 = batt_mv < 13'h0BB8;
    sense_async.current_below_term = batt_ma < {2'h0, setpoint.term_ma};
    {sense_async.junction_hot, sense_async.vbus_near_floor} = flags[3:2];
    {sense_async.low_side_reverse, sense_async.disable_pin} = flags[1:0];
    sense_async.batt_connected = 1'b1;
  end
endmodule
`default_nettype wire

// *** verif/battery_charge_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "battery_charge_cfg.svh"
module battery_charge_control_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, rd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, flags;
  logic [1:0] bresp, rresp, resp;
  logic [12:0] batt_mv;
  logic [10:0] batt_ma;
  battery_charge_pkg::sense_t sense_async;
  battery_charge_pkg::drive_t drive;
  battery_charge_pkg::setpoint_t setpoint;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, seed, c;
  int idx_q[$] = '{0, 1, 2, 4, 7};
  int val_q[$] = '{32'h10, 32'h08, 32'h08, 32'h80, 32'h00};
  battery_charge_control dut (.*);
  battery_model partner (.*);
  ////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Timeout counts as a failure.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 32'h1388)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ready is seen mid-cycle; release follows the taking edge.
  task automatic wr(input logic [2:0] i, input logic [7:0] d, output logic [1:0] r);
    logic ha, hw, busy;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {3'h0, i, 2'h0, 24'h0, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    busy = 1'b1;
    r = 2'h3;
    for (int k = 0; k < 40 && busy; k++)
    begin
      @(negedge aclk);
      {ha, hw, busy} = {awvalid && awready, wvalid && wready, !bvalid};
      if (bvalid) r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (!busy) bready <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [2:0] i, output logic [7:0] d, output logic [1:0] r);
    logic ha, busy;
    @(posedge aclk);
    araddr <= {3'h0, i, 2'h0};
    {arvalid, rready} <= 2'h3;
    busy = 1'b1;
    {d, r} = 10'h3;
    for (int k = 0; k < 40 && busy; k++)
    begin
      @(negedge aclk);
      {ha, busy} = {arvalid && arready, !rvalid};
      if (rvalid) {d, r} = {rdata[7:0], rresp};
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (!busy) rready <= 1'b0;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic set_batt(input logic [12:0] mv, input logic [10:0] ma, input logic [3:0] f);
    @(posedge aclk);
    {batt_mv, batt_ma, flags} <= {mv, ma, f};
  endtask
  // Bench model of the code tables.
  function automatic logic [31:0] float_exp(input int k);
    return (k > 32'h2E) ? 32'h1158 : 32'hDAC + 32'h14 * k;
  endfunction
  function automatic logic [31:0] chg_exp(input int k);
    return (k > 32'h9) ? 32'h60E : 32'h226 + 32'h64 * k;
  endfunction
  ////////////////////////////////////////
  initial
  begin
    seed = 32'hB38E4B2C;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {batt_mv, batt_ma, flags} = {13'h0CE4, 11'h1F4, 4'h0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    settle(8);
    foreach (idx_q[i])
    begin
      rdr(3'(idx_q[i]), rd, resp);
      check("reset value", rd, val_q[i]);
    end
    check("reset targets", {setpoint.float_mv, setpoint.charge_ma}, {13'hDD4, 11'h154});
    wr(3'h3, 8'hFF, resp);
    check("unmapped write", resp, 32'h2);
    rdr(3'h3, rd, resp);
    check("unmapped read", {rd, resp}, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      c = (i == 0) ? 32'h2E : (i == 1) ? 32'h2F : (i == 2) ? 32'h3F : $random(seed) & 32'h3F;
      wr(`REG2_IDX, 8'(c * 4), resp);
      settle(2);
      check("float", setpoint.float_mv, float_exp(c));
    end
    for (int k = 0; k < 16; k++)
    begin
      wr(`REG4_IDX, 8'(k * 8 + k % 8), resp);
      settle(2);
      check("charge", setpoint.charge_ma, chg_exp(k));
      check("term", setpoint.term_ma, 32'h32 * (k % 8 + 1));
    end
    wr(`REG4_IDX, 8'hFF, resp);
    settle(2);
    check("low current", setpoint.charge_ma, 32'h154);
    for (int i = 0; i < 4; i++)
    begin
      c = $random(seed) & 32'hF;
      wr(`REG1_IDX, 8'(c * 16 + 8), resp);
      rdr(`REG1_IDX, rd, resp);
      check("reg1", {rd, setpoint.input_limit_code, setpoint.weak_code}, c * 32'h101 + 32'h80);
    end
    wr(`REG1_IDX, 8'h0A, resp);
    settle(6);
    check("hiz", {drive.hiz_block, drive.pwm_on}, 32'h2);
    set_batt(13'h0708, 11'h1F4, 4'h0);
    wr(`REG1_IDX, 8'h00, resp);
    wr(`REG2_IDX, 8'h8C, resp);
    wr(`REG7_IDX, 8'h08, resp);
    wr(`REG4_IDX, 8'h23, resp);
    settle(6);
    check("precharge", {drive.linear_precharge, drive.path_linear, drive.power_good_n}, 32'h7);
    set_batt(13'h0E74, 11'h1F4, 4'h0);
    settle(6);
    check("pwm", {drive.pwm_on, drive.slew_limit, drive.linear_precharge}, 32'h6);
    set_batt(13'h1068, 11'h96, 4'h0);
    settle(8);
    rdr(`REG0_IDX, rd, resp);
    check("no termination", {rd[5:4], drive.status_pin}, 32'h2);
    wr(`REG1_IDX, 8'h08, resp);
    settle(8);
    rdr(`REG7_IDX, rd, resp);
    check("topoff", {rd[4], drive.status_pin}, 32'h3);
    rdr(`REG0_IDX, rd, resp);
    check("done bits", rd[5:4], 32'h2);
    set_batt(13'h1068, 11'h28, 4'h0);
    settle(8);
    rdr(`REG7_IDX, rd, resp);
    check("topoff end", {rd[4], drive.status_pin}, 32'h1);
    set_batt(13'h0FA0, 11'h28, 4'h0);
    settle(8);
    rdr(`REG0_IDX, rd, resp);
    check("recharge", rd[5:4], 32'h1);
    set_batt(13'h0FA0, 11'h28, 4'hE);
    settle(6);
    check("guards", {drive.thermal_cut, drive.input_cutback, drive.low_side_en}, 32'h6);
    set_batt(13'h0FA0, 11'h28, 4'h1);
    settle(8);
    rdr(`REG0_IDX, rd, resp);
    check("disabled", rd[5:4], 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
